// [src/strap_latch_regs.vh]
/*
 * Strap capture constants: field positions, reset values and strap defaults.
 * Assumes inclusion by the strap latch module only; definitions only.
 */
`ifndef STRAP_LATCH_REGS_VH
`define STRAP_LATCH_REGS_VH

`define ADDR_DEFAULT 5'h01
`define ADDR_UPPER_ZERO 2'h0
`define MODE_NORMAL_MII 3'h0
`define MODE_BACK_TO_BACK 3'h6
`define CTL0_ISOLATE_BIT 10
`define CTL0_AUTONEG_BIT 12
`define CTL0_DUPLEX_BIT 8
`define CTL16_WAKE_BIT 15
`define CTL16_BCAST_OFF_BIT 9
`define CTL0_RESET 16'h1100
`define CTL16_RESET 16'h0000
`define BCAST_ADDR 5'h00

`endif

// [src/phy_strap_latch.v]
/*
 * Strap capture for a 10/100 transceiver: samples straps at reset release,
 * seeds control register bits, decodes address and interface mode.
 * Assumes straps are board-level levels held stable around reset release and
 * a register write port from the management logic on the same clock.
 * Straps must hold for at least four clocks before release to pass the filter.
 * Writes that land in the capture cycle are dropped; the straps win there.
 */
// How it works
// - Three low address straps captured at reset release, any value 0 to 7.
// - Unfitted straps bias the address to 1 by default.
// - Address 0 answers as broadcast alongside own address by default.
// - Broadcast-off strap or writing register 16h bit 9 makes address 0 unique.
// - Address bits 4:3 fixed at zero.
// - Mode strap latched: 000 normal MII, 110 back-to-back, others reserved.
// - Wake enable strap copied into register 16h bit 15.
// - Isolate strap copied into register 0h bit 10.
// - Duplex strap copied into register 0h bit 8; high means half duplex.
// - Auto-negotiation strap copied into register 0h bit 12.
// - Test-tree strap latched; low enables pin-continuity test mode.
// - Strap pins are inputs during reset, outputs afterwards.
`timescale 1ns/100ps
`include "strap_latch_regs.vh"

module phy_strap_latch
(
    input wire mclk,
    input wire srst,
    // Board straps, asynchronous levels
    input wire [2:0] strapMgmtAddress,
    input wire [2:0] strapMode,
    input wire wakeOutputEnableStrap,
    input wire isolateStrap,
    input wire duplexStrap,
    input wire autonegEnableStrap,
    input wire broadcastDisableStrap,
    input wire testTreeStrap_n,
    // Register writes and access address, same clock
    input wire [15:0] ctl0WrData,
    input wire ctl0WrEn,
    input wire [15:0] ctl16WrData,
    input wire ctl16WrEn,
    input wire [4:0] accessAddress,
    // Pin direction, captured settings and decoded flags
    output wire strapPinOutEn,
    output wire [4:0] latchedMgmtAddress,
    output wire [2:0] interfaceMode,
    output wire modeBackToBack,
    output wire modeReserved,
    output wire [15:0] ctl0,
    output wire [15:0] ctl16,
    output wire isolateMode,
    output wire fullDuplex,
    output wire autonegEnable,
    output wire wakeOutputEnable,
    output wire broadcastEnable,
    output wire testTreeMode,
    output wire addressMatch
);

    // Straps come from pins: three-stage sync, accept when stages 2 and 3 agree
    localparam SW = 12;
    wire [SW-1:0] strapRaw = {testTreeStrap_n, broadcastDisableStrap,
        autonegEnableStrap, duplexStrap,
        isolateStrap, wakeOutputEnableStrap,
        strapMode, strapMgmtAddress};
    // Three-stage filter registers
    reg [SW-1:0] sync1_q;
    reg [SW-1:0] sync2_q;
    reg [SW-1:0] sync3_q;
    reg [SW-1:0] stable_q;

    // Captured state and its next value
    reg srstDly_q;
    reg [2:0] addr_q;
    reg [2:0] mode_q;
    reg bcastOff_q;
    reg testTree_q;
    reg [15:0] ctl0_q;
    reg [15:0] ctl16_q;
    reg [2:0] addr_d;
    reg [2:0] mode_d;
    reg bcastOff_d;
    reg testTree_d;
    reg [15:0] ctl0_d;
    reg [15:0] ctl16_d;

    // Decoded flags held in flops
    reg modeB2b_q;
    reg modeRsv_q;
    reg fullDuplex_q;
    reg bcastEn_q;
    reg testTreeMode_q;

    function isUnique;
        input strapOff;
        input [15:0] reg16;
        begin
            isUnique = strapOff | reg16[`CTL16_BCAST_OFF_BIT];
        end
    endfunction

    function isBackToBack;
        input [2:0] mode;
        begin
            isBackToBack = (mode == `MODE_BACK_TO_BACK);
        end
    endfunction

    function addrMatches;
        input [4:0] target;
        input [4:0] own;
        input bcastOn;
        begin
            addrMatches = (target == own) | (bcastOn & (target == `BCAST_ADDR));
        end
    endfunction

    genvar i;
    generate
        for (i = 0; i < SW; i = i + 1)
        begin : gSync
            // Per-bit filter; a bit still bouncing at release keeps its old value
            always @(posedge mclk)
            begin
                sync1_q[i] <= strapRaw[i];
                sync2_q[i] <= sync1_q[i];
                sync3_q[i] <= sync2_q[i];
                if (sync2_q[i] == sync3_q[i])
                    stable_q[i] <= sync3_q[i];
            end
        end
    endgenerate

    // Capture on the first edge after release; pins read only as inputs in reset
    always @*
    begin
        addr_d = addr_q;
        mode_d = mode_q;
        bcastOff_d = bcastOff_q;
        testTree_d = testTree_q;
        ctl0_d = ctl0_q;
        ctl16_d = ctl16_q;
        if (srst)
        begin
            addr_d = 3'h1;
            mode_d = `MODE_NORMAL_MII;
            bcastOff_d = 1'b0;
            testTree_d = 1'b1;
            ctl0_d = `CTL0_RESET;
            ctl16_d = `CTL16_RESET;
        end
        else if (srstDly_q)
        begin
            addr_d = stable_q[2:0];
            mode_d = stable_q[5:3];
            bcastOff_d = stable_q[10];
            testTree_d = stable_q[11];
            ctl0_d = `CTL0_RESET;
            ctl0_d[`CTL0_ISOLATE_BIT] = stable_q[7];
            ctl0_d[`CTL0_DUPLEX_BIT] = stable_q[8];
            ctl0_d[`CTL0_AUTONEG_BIT] = stable_q[9];
            ctl16_d = `CTL16_RESET;
            ctl16_d[`CTL16_WAKE_BIT] = stable_q[6];
        end
        else
        begin
            // Later writes only; straps not resampled until next release
            if (ctl0WrEn)
            begin
                ctl0_d = ctl0WrData;
            end
            if (ctl16WrEn)
            begin
                ctl16_d = ctl16WrData;
            end
        end
    end

    always @(posedge mclk)
    begin
        srstDly_q <= srst;
        addr_q <= addr_d;
        mode_q <= mode_d;
        bcastOff_q <= bcastOff_d;
        testTree_q <= testTree_d;
        ctl0_q <= ctl0_d;
        ctl16_q <= ctl16_d;

        // Flags from next state, so they change on the same edge as the image
        modeB2b_q <= isBackToBack(mode_d);
        modeRsv_q <= ~isBackToBack(mode_d) & (mode_d != `MODE_NORMAL_MII);
        fullDuplex_q <= ~ctl0_d[`CTL0_DUPLEX_BIT];
        bcastEn_q <= ~isUnique(bcastOff_d, ctl16_d);
        testTreeMode_q <= ~testTree_d;
    end

    assign strapPinOutEn = ~srst & ~srstDly_q;
    assign latchedMgmtAddress = {`ADDR_UPPER_ZERO, addr_q};
    assign interfaceMode = mode_q;
    assign modeBackToBack = modeB2b_q;
    assign modeReserved = modeRsv_q;
    assign ctl0 = ctl0_q;
    assign ctl16 = ctl16_q;
    assign isolateMode = ctl0_q[`CTL0_ISOLATE_BIT];
    assign fullDuplex = fullDuplex_q;
    assign autonegEnable = ctl0_q[`CTL0_AUTONEG_BIT];
    assign wakeOutputEnable = ctl16_q[`CTL16_WAKE_BIT];
    assign broadcastEnable = bcastEn_q;
    assign testTreeMode = testTreeMode_q;
    // Own address always answers; address 0 also answers while broadcast is on
    assign addressMatch = addrMatches(accessAddress, latchedMgmtAddress, bcastEn_q);

endmodule // phy_strap_latch

// [testbench/phy_strap_latch_asserts.sv]
/* Strap latch checker on the top ports. Assumes a bind from the bench top. */
`timescale 1ns/100ps
module phy_strap_latch_asserts(
    input wire mclk, srst, ctl0WrEn, ctl16WrEn, strapPinOutEn, isolateMode, fullDuplex,
    input wire broadcastEnable, addressMatch,
    input wire [4:0] accessAddress, latchedMgmtAddress,
    input wire [15:0] ctl0, ctl16, ctl16WrData
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence released; $fell(srst) ##0 !strapPinOutEn; endsequence
    a_pins_release: assert property (released |=> strapPinOutEn) else $error("pins");
    a_addr_upper: assert property (latchedMgmtAddress[4:3] == 2'h0) else $error("upper");
    a_own_match: assert property (accessAddress == latchedMgmtAddress |-> addressMatch) else $error("own");
    a_bcast_zero: assert property (broadcastEnable && accessAddress == 5'h00 |-> addressMatch) else $error("bc");
    a_unique_zero: assert property (!broadcastEnable && accessAddress != latchedMgmtAddress |-> !addressMatch)
        else $error("uniq");
    a_bcast_write: assert property (ctl16WrEn && ctl16WrData[9] && !$past(srst) |=> !broadcastEnable)
        else $error("bcw");
    a_ctl0_map: assert property (isolateMode == ctl0[10] && fullDuplex == !ctl0[8]) else $error("map");
    a_seed_hold: assert property (!ctl0WrEn && !ctl16WrEn && !$past(srst) |=> $stable(ctl0) && $stable(ctl16)
        && $stable(latchedMgmtAddress)) else $error("hold");
endmodule // phy_strap_latch_asserts

// [testbench/strap_board.sv]
/* Board straps: fitted resistors or the pins' weak bias. Assumes levels settle before reset ends. */
`timescale 1ns/100ps
module strap_board(
    input wire fitted,
    input wire [11:0] pull,
    output wire [2:0] strapMgmtAddress, strapMode,
    output wire wakeOutputEnableStrap, isolateStrap, duplexStrap, autonegEnableStrap, broadcastDisableStrap,
    output wire testTreeStrap_n
);
    // Unfitted: address 1, half duplex, autoneg on, test tree off
    assign {strapMgmtAddress, strapMode, wakeOutputEnableStrap, isolateStrap, duplexStrap, autonegEnableStrap,
        broadcastDisableStrap, testTreeStrap_n} = fitted ? pull : 12'h20d;
endmodule // strap_board

// [testbench/phy_strap_latch_tb_top.sv]
/* Bench: unfitted strap case, a broadcast-off write, fitted strap cases, then a register 0 write. Assumes strap_board drives straps. */
`timescale 1ns/100ps
module phy_strap_latch_tb_top;
    reg mclk = 1'b0, srst = 1'b1, fitted = 1'b0, ctl0WrEn = 1'b0, ctl16WrEn = 1'b0;
    reg [15:0] ctl0WrData = 16'h0000, ctl16WrData = 16'h0000;
    reg [11:0] pull = 12'h000, e;
    reg [4:0] accessAddress = 5'h00;
    wire [2:0] strapMgmtAddress, strapMode, interfaceMode;
    wire [4:0] latchedMgmtAddress;
    wire [15:0] ctl0, ctl16;
    wire wakeOutputEnableStrap, isolateStrap, duplexStrap, autonegEnableStrap, broadcastDisableStrap, testTreeStrap_n;
    wire strapPinOutEn, modeBackToBack, modeReserved, isolateMode, fullDuplex, autonegEnable, wakeOutputEnable;
    wire broadcastEnable, testTreeMode, addressMatch;
    integer n_errors = 0, checks = 0;
    always #20 mclk = ~mclk;
    strap_board u_strap_board(.*);
    phy_strap_latch u_phy_strap_latch(.*);
    task chk(input string s, input [15:0] x, input [15:0] g);
    begin
        checks = checks + 1;
        if (g !== x)
        begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s exp %h got %h", s, x, g);
        end
    end
    endtask
    task boot(input f, input [11:0] p);
    begin
        fitted = f;
        pull = p;
        e = f ? p : 12'h20d;
        srst = 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("pinoff", 16'h0000, strapPinOutEn);
        srst = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("addr", {13'h0000, e[11:9]}, latchedMgmtAddress);
        chk("mode", e[8:6], interfaceMode);
        chk("rsv", e[8:6] != 3'h0 && e[8:6] != 3'h6, modeReserved);
        chk("ctl0", {3'h0, e[2], 1'b0, e[4], 1'b0, e[3], 8'h00}, ctl0);
        chk("ctl16", {e[5], 15'h0000}, ctl16);
        chk("bcast", !e[1], broadcastEnable);
        chk("tree", !e[0], testTreeMode);
        chk("match", e[11:9] == 3'h0 || !e[1], addressMatch);
        chk("b2b", e[8:6] == 3'h6, modeBackToBack);
        chk("iso", e[4], isolateMode);
        chk("full", !e[3], fullDuplex);
        chk("aneg", e[2], autonegEnable);
        chk("wake", e[5], wakeOutputEnable);
        chk("pinon", 16'h0001, strapPinOutEn);
        $display("strap case %h done", e);
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    initial
    begin
        boot(1'b0, 12'h000);
        ctl16WrData = 16'h0200;
        ctl16WrEn = 1'b1;
        @(posedge mclk) #1 ctl16WrEn = 1'b0;
        chk("bcoff", 16'h0000, addressMatch);
        fitted = 1'b1;
        pull = 12'hfb2;
        repeat (6) @(posedge mclk);
        #1 chk("hold", 16'h0200, ctl16);
        chk("keep", 16'h0001, latchedMgmtAddress);
        $display("write and hold done");
        boot(1'b1, 12'hfb2);
        boot(1'b1, 12'h14d);
        boot(1'b1, 12'h5b0);
        ctl0WrData = 16'h1100;
        ctl0WrEn = 1'b1;
        @(posedge mclk) #1 ctl0WrEn = 1'b0;
        chk("ctl0w", 16'h1100, ctl0);
        chk("fullw", 16'h0000, fullDuplex);
        chk("isow", 16'h0000, isolateMode);
        $display("register 0 write done");
        stop_test;
    end
endmodule // phy_strap_latch_tb_top
bind phy_strap_latch phy_strap_latch_asserts u_phy_strap_latch_asserts(.*);
